// ---- logic/linear_compare.sv ----
// Registered comparison of two values in Linear numeric format.
// Assumes both inputs come from logic on the same clock.
`include "temp_limit_defines.svh"

module linear_compare
   import temp_limit_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [15:0] a_i,
   input  wire logic [15:0] b_i,
   output logic             a_lt_b_o,
   output logic             a_gt_b_o
);

   cmp_state_t s_q;
   cmp_state_t s_d;

   // Mantissa scaled by two to the exponent, in a common fixed-point grid
   function automatic logic signed [`TL_FIX_W-1:0] lin_fix(input logic [15:0] v);
      logic signed [`TL_FIX_W-1:0] m;
      logic [5:0]                  sh;
      m  = `TL_FIX_W'(signed'(v[`TL_MANT_HI:0]));
      sh = 6'(signed'(v[`TL_EXP_HI:`TL_EXP_LO]) + `TL_EXP_BIAS);
      return m <<< sh;
   endfunction

   // Compare in fixed point
   always_comb begin
      s_d    = s_q;
      s_d.lt = lin_fix(a_i) < lin_fix(b_i);
      s_d.gt = lin_fix(a_i) > lin_fix(b_i);
   end

   // State register
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign a_lt_b_o = s_q.lt;
   assign a_gt_b_o = s_q.gt;

endmodule

// ---- logic/temp_limit_defines.svh ----
// Command codes, field positions, reset values and counts for the temperature limit block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TEMP_LIMIT_DEFINES_SVH
`define TEMP_LIMIT_DEFINES_SVH

// Command codes of the threshold and action registers
`define TL_HOT_WARN_CODE    8'h51
`define TL_COLD_WARN_CODE   8'h52
`define TL_COLD_FAULT_CODE  8'h53
`define TL_COLD_ACTION_CODE 8'h54

// Field positions inside the action register
`define TL_RESP_HI  7
`define TL_RESP_LO  6
`define TL_RETRY_HI 5
`define TL_RETRY_LO 3
`define TL_DLY_HI   2
`define TL_DLY_LO   0

// Retry codes with special meaning
`define TL_RETRY_NONE    3'h0
`define TL_RETRY_FOREVER 3'h7

// Reset values
`define TL_HOT_WARN_RST    16'h0000
`define TL_COLD_WARN_RST   16'h0000
`define TL_COLD_FAULT_RST  16'h0000
`define TL_COLD_ACTION_RST 8'h00

// Linear format layout and conversion
`define TL_MANT_HI  10
`define TL_EXP_HI   15
`define TL_EXP_LO   11
`define TL_EXP_BIAS 16
`define TL_FIX_W    48

`endif

// ---- logic/temp_limit_fault_response.sv ----
// Temperature thresholds and under-temperature fault response with timed retries.
// Assumes the command decoder delivers register accesses as one-cycle strobes and a
// delay-unit tick arrives from the time-unit configuration elsewhere.
`include "temp_limit_defines.svh"

// What this block does
// - Holds a writable 16-bit Linear over-temperature warning threshold.
// - Holds a writable 16-bit Linear under-temperature warning threshold.
// - Holds a 16-bit Linear under-temperature fault threshold used for fault detection.
// - Response 00 ignores the fault; output keeps running.
// - Response 01 runs on for the delay, then applies retry field if fault remains.
// - Response 10 disables output at once, then follows the retry field.
// - Response 11 holds output off while faulted, re-enables when fault goes.
// - Retry 000 makes no restart; output off until fault is cleared.
// - Retry 001 to 110 allow one to six restarts, then stay off until cleared.
// - Restart attempts start apart by the delay count times the delay unit.
// - Retry 111 retries forever until commanded off or another fault stops it.
// - Delay count field selects two to the field value units, 1 to 128.
// - One delay count serves run-on time and restart spacing; unit comes from outside.
module temp_limit_fault_response
   import temp_limit_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        cmd_wr_i,
   input  wire logic        cmd_rd_i,
   input  wire logic [7:0]  cmd_code_i,
   input  wire logic [15:0] cmd_data_i,
   input  wire logic [15:0] temp_i,
   input  wire logic        unit_tick_i,
   input  wire logic        ctrl_pin_i,
   input  wire logic        op_on_i,
   input  wire logic        other_fault_i,
   input  wire logic        fault_clear_i,
   output logic [15:0]      rd_data_o,
   output logic             rd_valid_o,
   output logic             cmd_nak_o,
   output logic             out_en_o,
   output logic             hot_warn_o,
   output logic             cold_warn_o,
   output logic             cold_fault_o,
   output logic             latched_off_o,
   output logic [2:0]       tries_o
);

   top_state_t  s_q;
   top_state_t  s_d;
   logic [15:0] thr   [3];
   logic [2:0]  cmp_lt;
   logic [2:0]  cmp_gt;

   // Comparator operands: hot warning, cold warning, cold fault
   assign thr[0] = s_q.hot_thr;
   assign thr[1] = s_q.cold_warn_thr;
   assign thr[2] = s_q.cold_fault_thr;

   // One comparator per threshold
   for (genvar i = 0; i < 3; i++) begin : g_cmp
      linear_compare u_cmp (
         .sys_clk_i (sys_clk_i),
         .sys_rst_i (sys_rst_i),
         .a_i       (temp_i),
         .b_i       (thr[i]),
         .a_lt_b_o  (cmp_lt[i]),
         .a_gt_b_o  (cmp_gt[i])
      );
   end

   // Next state: register access, pin sync, fault supervision
   always_comb begin
      logic       fault;
      logic       cmd_on;
      logic       tick_done;
      logic       retry_ok;
      logic [2:0] retry;
      logic [7:0] units;
      resp_t      resp;
      s_d         = s_q;
      resp        = resp_t'(s_q.action[`TL_RESP_HI:`TL_RESP_LO]);
      retry       = s_q.action[`TL_RETRY_HI:`TL_RETRY_LO];
      units       = 8'h01 << s_q.action[`TL_DLY_HI:`TL_DLY_LO];
      fault       = cmp_lt[2];
      cmd_on      = s_q.ctrl_on && op_on_i;
      tick_done   = unit_tick_i && (s_q.timer == 8'h01);
      retry_ok    = (retry == `TL_RETRY_FOREVER) || (s_q.tries < retry);
      s_d.rd_valid = 1'b0;
      s_d.nak      = 1'b0;
      // Control pin: three stages, taken once the last two agree
      s_d.sync = {s_q.sync[1:0], ctrl_pin_i};
      if (s_q.sync[1] == s_q.sync[2]) begin
         s_d.ctrl_on = s_q.sync[2];
      end
      // Register writes
      if (cmd_wr_i) begin
         case (cmd_code_i)
            `TL_HOT_WARN_CODE:    s_d.hot_thr = cmd_data_i;
            `TL_COLD_WARN_CODE:   s_d.cold_warn_thr = cmd_data_i;
            `TL_COLD_FAULT_CODE:  s_d.cold_fault_thr = cmd_data_i;
            `TL_COLD_ACTION_CODE: s_d.action = cmd_data_i[7:0];
            default:              s_d.nak = 1'b1;
         endcase
      end
      // Register reads
      if (cmd_rd_i) begin
         s_d.rd_valid = 1'b1;
         case (cmd_code_i)
            `TL_HOT_WARN_CODE:    s_d.rd_data = s_q.hot_thr;
            `TL_COLD_WARN_CODE:   s_d.rd_data = s_q.cold_warn_thr;
            `TL_COLD_FAULT_CODE:  s_d.rd_data = s_q.cold_fault_thr;
            `TL_COLD_ACTION_CODE: s_d.rd_data = {8'h00, s_q.action};
            default: begin
               s_d.rd_data = 16'h0000;
               s_d.nak     = 1'b1;
            end
         endcase
      end
      // Limit flags
      s_d.hot_warn   = cmp_gt[0];
      s_d.cold_warn  = cmp_lt[1];
      s_d.cold_fault = fault;
      // Delay timer counts unit ticks down to zero
      if (unit_tick_i && (s_q.timer != 8'h00)) begin
         s_d.timer = s_q.timer - 8'h01;
      end
      case (s_q.fsm)
         ST_OFF: begin
            s_d.fsm = ST_RUN;
         end
         ST_RUN: begin
            if (fault) begin
               case (resp)
                  RESP_IGNORE: s_d.fsm = ST_RUN;
                  RESP_RUN_ON: begin
                     s_d.fsm   = ST_RUNON;
                     s_d.timer = units;
                  end
                  RESP_STOP: begin
                     s_d.fsm   = retry_ok ? ST_WAIT : ST_LATCH;
                     s_d.timer = units;
                  end
                  RESP_HOLD:   s_d.fsm = ST_HOLD;
                  default:     s_d.fsm = ST_RUN;
               endcase
            end
         end
         ST_RUNON: begin
            if (tick_done) begin
               if (!fault) begin
                  s_d.fsm = ST_RUN;
               end else begin
                  s_d.fsm   = retry_ok ? ST_WAIT : ST_LATCH;
                  s_d.timer = units;
               end
            end
         end
         ST_WAIT: begin
            if (tick_done) begin
               s_d.fsm = ST_RUN;
               if (retry != `TL_RETRY_FOREVER) begin
                  s_d.tries = s_q.tries + 3'h1;
               end
            end
         end
         ST_LATCH: begin
            if (fault_clear_i) begin
               s_d.fsm = ST_RUN;
            end
         end
         ST_HOLD: begin
            if (!fault) begin
               s_d.fsm = ST_RUN;
            end
         end
         default: s_d.fsm = ST_OFF;
      endcase
      // Command off or another fault overrides the state machine and the attempt count
      if (!cmd_on || other_fault_i) begin
         s_d.fsm   = ST_OFF;
         s_d.tries = 3'h0;
      end
      if (fault_clear_i) begin
         s_d.tries = 3'h0;
      end
      s_d.out_en      = (s_d.fsm == ST_RUN) || (s_d.fsm == ST_RUNON);
      s_d.latched_off = (s_d.fsm == ST_LATCH);
   end

   // State register
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q                <= '0;
         s_q.fsm            <= ST_OFF;
         s_q.hot_thr        <= `TL_HOT_WARN_RST;
         s_q.cold_warn_thr  <= `TL_COLD_WARN_RST;
         s_q.cold_fault_thr <= `TL_COLD_FAULT_RST;
         s_q.action         <= `TL_COLD_ACTION_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign rd_data_o     = s_q.rd_data;
   assign rd_valid_o    = s_q.rd_valid;
   assign cmd_nak_o     = s_q.nak;
   assign out_en_o      = s_q.out_en;
   assign hot_warn_o    = s_q.hot_warn;
   assign cold_warn_o   = s_q.cold_warn;
   assign cold_fault_o  = s_q.cold_fault;
   assign latched_off_o = s_q.latched_off;
   assign tries_o       = s_q.tries;

endmodule

// ---- logic/temp_limit_pkg.sv ----
// Types shared by the temperature limit block.
// Assumes the defines header is on the include path.
`include "temp_limit_defines.svh"

package temp_limit_pkg;

   // Response to an under-temperature fault
   typedef enum logic [1:0] {
      RESP_IGNORE = 2'b00,
      RESP_RUN_ON = 2'b01,
      RESP_STOP   = 2'b10,
      RESP_HOLD   = 2'b11
   } resp_t;

   // Output supervision states
   typedef enum logic [2:0] {
      ST_OFF   = 3'b000,
      ST_RUN   = 3'b001,
      ST_RUNON = 3'b010,
      ST_WAIT  = 3'b011,
      ST_LATCH = 3'b100,
      ST_HOLD  = 3'b101
   } fsm_t;

   // Whole state of the top module
   typedef struct packed {
      fsm_t        fsm;
      logic [15:0] hot_thr;
      logic [15:0] cold_warn_thr;
      logic [15:0] cold_fault_thr;
      logic [7:0]  action;
      logic [7:0]  timer;
      logic [2:0]  tries;
      logic [2:0]  sync;
      logic        ctrl_on;
      logic        out_en;
      logic        hot_warn;
      logic        cold_warn;
      logic        cold_fault;
      logic        latched_off;
      logic [15:0] rd_data;
      logic        rd_valid;
      logic        nak;
   } top_state_t;

   // Whole state of one comparator
   typedef struct packed {
      logic lt;
      logic gt;
   } cmp_state_t;

endpackage

// ---- verif/host_model.sv ----
// Host side model issuing register writes and reads as one-cycle strobes.
// Assumes the block answers a read in the cycle after the strobe edge.
module host_model (
   input  wire logic        sys_clk_i,
   output logic             cmd_wr_o,
   output logic             cmd_rd_o,
   output logic [7:0]       cmd_code_o,
   output logic [15:0]      cmd_data_o,
   input  wire logic [15:0] rd_data_i,
   input  wire logic        rd_valid_i,
   input  wire logic        cmd_nak_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      {cmd_wr_o, cmd_rd_o, cmd_code_o, cmd_data_o} = 26'h0;
   end
   // One write; idle lines then show the inverse of the last value
   task automatic wr(input logic [7:0] code, input logic [15:0] data);
      @(posedge sys_clk_i) {cmd_wr_o, cmd_code_o, cmd_data_o} <= {1'b1, code, data};
      @(posedge sys_clk_i) {cmd_wr_o, cmd_code_o, cmd_data_o} <= {1'b0, ~code, ~data};
   endtask
   // One read; the answer is taken while it stands
   task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic nak);
      @(posedge sys_clk_i) {cmd_rd_o, cmd_code_o} <= {1'b1, code};
      @(posedge sys_clk_i) {cmd_rd_o, cmd_code_o} <= {1'b0, ~code};
      @(negedge sys_clk_i);
      data = rd_valid_i ? rd_data_i : 16'hxxxx;
      nak = cmd_nak_i;
   endtask
endmodule

// ---- verif/temp_limit_fault_response_tb_top.sv ----
// Self-checking bench of the temperature fault response block.
// Assumes the host model drives the register strobes; unit ticks come from here.
module temp_limit_fault_response_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] warm = 16'h0019;
   localparam logic [15:0] cold = 16'h0005;
   logic        sys_clk_i, sys_rst_i, cmd_wr_i, cmd_rd_i, unit_tick_i, ctrl_pin_i, op_on_i;
   logic        other_fault_i, fault_clear_i, rd_valid_o, cmd_nak_o, out_en_o, hot_warn_o;
   logic        cold_warn_o, cold_fault_o, latched_off_o, nak;
   logic [2:0]  tries_o, r, d;
   logic [7:0]  cmd_code_i;
   logic [15:0] cmd_data_i, temp_i, rd_data_o, rdat, v;
   int          n_errors, checks_done;

   temp_limit_fault_response dut_u (.sys_clk_i, .sys_rst_i, .cmd_wr_i, .cmd_rd_i, .cmd_code_i,
      .cmd_data_i, .temp_i, .unit_tick_i, .ctrl_pin_i, .op_on_i, .other_fault_i, .fault_clear_i,
      .rd_data_o, .rd_valid_o, .cmd_nak_o, .out_en_o, .hot_warn_o, .cold_warn_o, .cold_fault_o,
      .latched_off_o, .tries_o);
   host_model host_u (.sys_clk_i, .cmd_wr_o(cmd_wr_i), .cmd_rd_o(cmd_rd_i),
      .cmd_code_o(cmd_code_i), .cmd_data_o(cmd_data_i), .rd_data_i(rd_data_o),
      .rd_valid_i(rd_valid_o), .cmd_nak_i(cmd_nak_o));

   // Clock
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // Comparison, waits and stimulus helpers
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge sys_clk_i) unit_tick_i <= 1'b1;
         @(posedge sys_clk_i) unit_tick_i <= 1'b0;
      end
      cyc(3);
   endtask
   task automatic set_temp(input logic [15:0] t);
      @(posedge sys_clk_i) temp_i <= t;
      cyc(3);
   endtask
   task automatic end_sim();
      $display("Counts: %0d checks, %0d mismatches", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Warm start with a new action, cleared fault and output back on
   task automatic arm(input logic [7:0] act);
      set_temp(warm);
      host_u.wr(8'h54, {8'h00, act});
      @(posedge sys_clk_i) fault_clear_i <= 1'b1;
      @(posedge sys_clk_i) fault_clear_i <= 1'b0;
      cyc(1);
      chk(16'(tries_o), 16'h0);
      // Command-off pulse leaves any wait or run-on state behind
      @(posedge sys_clk_i) op_on_i <= 1'b0;
      @(posedge sys_clk_i) op_on_i <= 1'b1;
      cyc(1);
      for (int i = 0; i < 40 && out_en_o !== 1'b1; i++) cyc(1);
      chk(16'({out_en_o, tries_o}), 16'h8);
      if (out_en_o !== 1'b1) end_sim();
   endtask

   // Main sequence
   initial begin
      {sys_rst_i, ctrl_pin_i, op_on_i, unit_tick_i, other_fault_i, fault_clear_i} = 6'h38;
      temp_i = warm;
      n_errors = 0;
      checks_done = 0;
      void'($urandom(75867));
      repeat (6) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         host_u.rd(8'h51 + 8'(i), rdat, nak);
         chk(rdat, 16'h0000);
         chk(16'(nak), 16'(i == 4));
         v = 16'($urandom);
         host_u.wr(8'h51 + 8'(i), v);
         host_u.rd(8'h51 + 8'(i), rdat, nak);
         chk(rdat, i == 4 ? 16'h0 : (i == 3 ? {8'h00, v[7:0]} : v));
      end
      host_u.wr(8'h54, 16'h0000);
      host_u.wr(8'h51, 16'h0050);
      host_u.wr(8'h52, 16'h000f);
      host_u.wr(8'h53, 16'h000a);
      $display("Test done: registers");
      set_temp(16'h0060);
      chk(16'({hot_warn_o, cold_warn_o, cold_fault_o}), 16'h4);
      set_temp(16'h000a + 16'($urandom_range(4)));
      chk(16'({hot_warn_o, cold_warn_o, cold_fault_o}), 16'h2);
      set_temp(cold);
      chk(16'({hot_warn_o, cold_warn_o, cold_fault_o}), 16'h3);
      $display("Test done: thresholds");
      arm(8'h00);
      set_temp(cold);
      cyc(20);
      chk(16'(out_en_o), 16'h1);
      d = 3'($urandom_range(7));
      arm({5'b01000, d});
      set_temp(cold);
      tick((1 << d) - 1);
      chk(16'(out_en_o), 16'h1);
      tick(1);
      chk(16'({out_en_o, latched_off_o}), 16'h1);
      arm(8'h80);
      set_temp(cold);
      chk(16'({out_en_o, latched_off_o}), 16'h1);
      tick(4);
      chk(16'({out_en_o, tries_o}), 16'h0);
      arm(8'hc0);
      set_temp(cold);
      chk(16'({out_en_o, latched_off_o}), 16'h0);
      set_temp(warm);
      chk(16'(out_en_o), 16'h1);
      $display("Test done: responses");
      r = 3'($urandom_range(6, 1));
      arm({2'b10, r, 3'b001});
      set_temp(cold);
      for (int k = 0; k < r; k++) begin
         tick(1);
         chk(16'(tries_o), 16'(k));
         tick(1);
         chk(16'(tries_o), 16'(k + 1));
      end
      tick(2);
      chk(16'({latched_off_o, out_en_o, tries_o}), 16'h10 | 16'(r));
      // Fault gone but not cleared: output stays off until the clear
      set_temp(warm);
      chk(16'({latched_off_o, out_en_o, tries_o}), 16'h10 | 16'(r));
      @(posedge sys_clk_i) fault_clear_i <= 1'b1;
      @(posedge sys_clk_i) fault_clear_i <= 1'b0;
      cyc(1);
      chk(16'({latched_off_o, out_en_o, tries_o}), 16'h8);
      $display("Test done: retries");
      arm(8'hb8);
      set_temp(cold);
      tick(9);
      chk(16'({latched_off_o, tries_o}), 16'h0);
      @(posedge sys_clk_i) op_on_i <= 1'b0;
      cyc(3);
      chk(16'({out_en_o, tries_o}), 16'h0);
      @(posedge sys_clk_i) op_on_i <= 1'b1;
      arm(8'h00);
      @(posedge sys_clk_i) other_fault_i <= 1'b1;
      cyc(3);
      chk(16'(out_en_o), 16'h0);
      @(posedge sys_clk_i) other_fault_i <= 1'b0;
      arm(8'h00);
      // Control pin off passes the three-stage resync before the output drops
      @(posedge sys_clk_i) ctrl_pin_i <= 1'b0;
      cyc(6);
      chk(16'({out_en_o, tries_o}), 16'h0);
      @(posedge sys_clk_i) ctrl_pin_i <= 1'b1;
      arm(8'h00);
      $display("Test done: off paths");
      end_sim();
   end
endmodule

// ---- verif/temp_limit_props.sv ----
// Checker of the register port and output control of the fault response block.
// Assumes it is bound to the block and sees only its ports.
module temp_limit_props (
   input wire logic        sys_clk_i,
   input wire logic        sys_rst_i,
   input wire logic        cmd_wr_i,
   input wire logic        cmd_rd_i,
   input wire logic [7:0]  cmd_code_i,
   input wire logic        op_on_i,
   input wire logic        other_fault_i,
   input wire logic        fault_clear_i,
   input wire logic [15:0] rd_data_o,
   input wire logic        rd_valid_o,
   input wire logic        cmd_nak_o,
   input wire logic        out_en_o,
   input wire logic        latched_off_o,
   input wire logic [2:0]  tries_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // Access to a code outside the four registers
   logic unmapped;
   assign unmapped = (cmd_wr_i || cmd_rd_i) && (cmd_code_i < 8'h51 || cmd_code_i > 8'h54);
   // Register port answers
   a_read_answered: assert property (cmd_rd_i |=> rd_valid_o)
      else $error("read strobe not answered");
   a_valid_has_cause: assert property (rd_valid_o |-> $past(cmd_rd_i))
      else $error("read valid without a read");
   a_nak_on_unmapped: assert property (unmapped |=> cmd_nak_o)
      else $error("unmapped access not refused");
   a_read_data_holds: assert property ($changed(rd_data_o) |-> rd_valid_o)
      else $error("read data moved without a read");
   // Output control and attempt counter
   a_off_command_stops: assert property (!op_on_i |-> ##[1:2] !out_en_o)
      else $error("output still on after off command");
   a_other_fault_stops: assert property (other_fault_i |-> ##[1:2] !out_en_o)
      else $error("output still on after other fault");
   a_clear_zeroes_tries: assert property (fault_clear_i && op_on_i |=> tries_o == 3'h0)
      else $error("attempt count kept after clear");
   a_latched_is_dark: assert property (latched_off_o |-> !out_en_o)
      else $error("output on while latched off");
   a_tries_step_one: assert property ($changed(tries_o) |->
      tries_o == $past(tries_o) + 3'h1 || tries_o == 3'h0)
      else $error("attempt count jumped");
   c_read: cover property (rd_valid_o);
   c_latched: cover property (latched_off_o && tries_o != 3'h0);
   c_restart: cover property ($rose(out_en_o) && tries_o != 3'h0);
endmodule

bind temp_limit_fault_response temp_limit_props props_u (.sys_clk_i, .sys_rst_i, .cmd_wr_i,
   .cmd_rd_i, .cmd_code_i, .op_on_i, .other_fault_i, .fault_clear_i, .rd_data_o, .rd_valid_o,
   .cmd_nak_o, .out_en_o, .latched_off_o, .tries_o);
